/* File: rtl/dqtc_term_ctrl.v */
/*
 Data-line termination timing control of a low-power DDR device.
 Assumes the command decoder on ref_clk gives one-cycle command
 strobes; clock-enable arrives from a pin and is synchronised here.
*/
`timescale 1ns/1ps
`include "dqtc_regs.vh"

module dqtc_term_ctrl (
    ref_clk,
    reset,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    cmd_write1,
    cmd_mask_write1,
    cmd_mpc_wr_fifo,
    cmd_cas2,
    power_down,
    self_refresh,
    cke_pin,
    dq_term_en,
    dqs_term_en,
    term_resistance_value
);
    input wire ref_clk;
    input wire reset;
    input wire [7:0] reg_addr;
    input wire [31:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [31:0] reg_rdata;
    input wire cmd_write1;
    input wire cmd_mask_write1;
    input wire cmd_mpc_wr_fifo;
    input wire cmd_cas2;
    input wire power_down;
    input wire self_refresh;
    input wire cke_pin;
    output reg dq_term_en;
    output reg dqs_term_en;
    output reg [2:0] term_resistance_value;

    // ************************************************************
    // Window states
    // ************************************************************
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_WAIT_ON = 3'h2;
    localparam [2:0] ST_ON = 3'h4;

    // ************************************************************
    // Latency lookup
    // ************************************************************
    // Returns {valid, on latency, off latency}; bins below the
    // table floor answer invalid so no window is ever opened.
    function [12:0] lat_lookup;
        input setb;
        input [2:0] bin;
        begin
            lat_lookup = 13'h0000;
            case ({setb, bin})
                4'h3: lat_lookup = {1'b1, `DQTC_A_ON_3, `DQTC_A_OFF_3};
                4'h4: lat_lookup = {1'b1, `DQTC_A_ON_4, `DQTC_A_OFF_4};
                4'h5: lat_lookup = {1'b1, `DQTC_A_ON_5, `DQTC_A_OFF_5};
                4'h6: lat_lookup = {1'b1, `DQTC_A_ON_6, `DQTC_A_OFF_6};
                4'h7: lat_lookup = {1'b1, `DQTC_A_ON_7, `DQTC_A_OFF_7};
                4'ha: lat_lookup = {1'b1, `DQTC_B_ON_2, `DQTC_B_OFF_2};
                4'hb: lat_lookup = {1'b1, `DQTC_B_ON_3, `DQTC_B_OFF_3};
                4'hc: lat_lookup = {1'b1, `DQTC_B_ON_4, `DQTC_B_OFF_4};
                4'hd: lat_lookup = {1'b1, `DQTC_B_ON_5, `DQTC_B_OFF_5};
                4'he: lat_lookup = {1'b1, `DQTC_B_ON_6, `DQTC_B_OFF_6};
                4'hf: lat_lookup = {1'b1, `DQTC_B_ON_7, `DQTC_B_OFF_7};
                default: lat_lookup = 13'h0000;
            endcase
        end
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    reg [2:0] mode_ff;
    reg [`DQTC_CFG_MSB:0] cfg_ff;
    reg cke_meta_ff;
    reg cke_sync_ff;
    reg pend_ff;
    reg nxt_pend;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [5:0] on_cnt_ff;
    reg [5:0] nxt_on_cnt;
    reg [5:0] off_cnt_ff;
    reg [5:0] nxt_off_cnt;
    reg nxt_dq_term;
    reg nxt_dqs_term;
    reg [31:0] nxt_rdata;

    wire [12:0] lat;
    wire lat_valid;
    wire [5:0] on_lat;
    wire [5:0] off_lat;
    wire term_enabled;
    wire wr_cmd;
    wire start;
    wire win_on;
    wire wlev;

    assign lat = lat_lookup(cfg_ff[`DQTC_CFG_SETB_BIT],
                            cfg_ff[`DQTC_CFG_BIN_MSB:`DQTC_CFG_BIN_LSB]);
    assign lat_valid = lat[12];
    assign on_lat = lat[11:6];
    assign off_lat = cfg_ff[`DQTC_CFG_BL32_BIT] ? lat[5:0] + `DQTC_BL32_EXTRA : lat[5:0];
    assign term_enabled = (mode_ff != 3'h0);
    assign wlev = cfg_ff[`DQTC_CFG_WLEV_BIT];
    assign wr_cmd = cmd_write1 | cmd_mask_write1 | cmd_mpc_wr_fifo;
    assign start = cmd_cas2 & (pend_ff | wr_cmd) & lat_valid & term_enabled;
    assign win_on = (state_ff == ST_ON);

    // ************************************************************
    // Register port and clock-enable synchroniser
    // ************************************************************
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_ff <= `DQTC_MODE_RST;
            cfg_ff <= `DQTC_CFG_RST;
            cke_meta_ff <= 1'b0;
            cke_sync_ff <= 1'b0;
        end else begin
            cke_meta_ff <= cke_pin;
            cke_sync_ff <= cke_meta_ff;
            if (reg_wr && reg_addr == `DQTC_OFS_MODE) begin
                mode_ff <= reg_wdata[`DQTC_MODE_CODE_MSB:0];
            end
            if (reg_wr && reg_addr == `DQTC_OFS_CFG) begin
                cfg_ff <= reg_wdata[`DQTC_CFG_MSB:0];
            end
        end
    end

    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `DQTC_OFS_MODE: nxt_rdata = {29'h0, mode_ff};
                `DQTC_OFS_CFG: nxt_rdata = {26'h0, cfg_ff};
                `DQTC_OFS_STAT: nxt_rdata = {27'h0, cke_sync_ff, lat_valid,
                                             dqs_term_en, dq_term_en, win_on};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Write window sequencer
    // ************************************************************
    // A later CAS-2 during an open window restarts the off count,
    // so back-to-back writes keep termination on without a gap.
    always @* begin
        nxt_state = state_ff;
        nxt_on_cnt = on_cnt_ff;
        nxt_off_cnt = off_cnt_ff;
        nxt_pend = pend_ff;
        if (wr_cmd) begin
            nxt_pend = 1'b1;
        end
        if (cmd_cas2) begin
            nxt_pend = 1'b0;
        end
        case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_on_cnt = on_lat;
                    nxt_off_cnt = off_lat;
                    nxt_state = ST_WAIT_ON;
                end
            end
            ST_WAIT_ON: begin
                nxt_off_cnt = off_cnt_ff - 6'h01;
                if (on_cnt_ff == 6'h01) begin
                    nxt_state = ST_ON;
                end else begin
                    nxt_on_cnt = on_cnt_ff - 6'h01;
                end
                if (start) begin
                    nxt_off_cnt = off_lat;
                end
            end
            ST_ON: begin
                if (start) begin
                    nxt_off_cnt = off_lat;
                end else if (off_cnt_ff == 6'h01) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_off_cnt = off_cnt_ff - 6'h01;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        // Dropping the enable mid-window closes it at once
        if (!term_enabled) begin
            nxt_state = ST_IDLE;
        end
    end

    // ************************************************************
    // Pin-facing termination decision
    // ************************************************************
    always @* begin
        nxt_dq_term = term_enabled & win_on;
        nxt_dqs_term = term_enabled & win_on;
        if (wlev) begin
            nxt_dq_term = 1'b0;
            nxt_dqs_term = term_enabled;
        end else if (power_down) begin
            nxt_dq_term = 1'b0;
            nxt_dqs_term = 1'b0;
        end else if (self_refresh) begin
            nxt_dq_term = cke_sync_ff & term_enabled;
            nxt_dqs_term = cke_sync_ff & term_enabled;
        end
    end

    // ************************************************************
    // State and output flops
    // ************************************************************
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            on_cnt_ff <= 6'h00;
            off_cnt_ff <= 6'h00;
            pend_ff <= 1'b0;
            dq_term_en <= 1'b0;
            dqs_term_en <= 1'b0;
            term_resistance_value <= 3'h0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            on_cnt_ff <= nxt_on_cnt;
            off_cnt_ff <= nxt_off_cnt;
            pend_ff <= nxt_pend;
            dq_term_en <= nxt_dq_term;
            dqs_term_en <= nxt_dqs_term;
            term_resistance_value <= mode_ff;
            reg_rdata <= nxt_rdata;
        end
    end

endmodule

/* File: rtl/dqtc_regs.vh */
/*
 Constants for the data-line termination timing block:
 register offsets, field positions, reset values and latency counts.
 Assumes a byte-addressed plain register port with 32-bit data.
*/
// Overview of operation
// - Termination enabled but no write in progress keeps data lines at high impedance.
// - WRITE-1, MASK WRITE-1 or MPC write-FIFO arms termination automatically, no pin.
// - After the write burst ends, termination returns to high impedance automatically.
// - Turn-on latency counts clock cycles from the CAS-2 command of the write.
// - Turn-on window starts no earlier than its minimum, fully on by its maximum.
// - Turn-off latency counts clock cycles from the same CAS-2 command.
// - Turn-off window begins no earlier than its minimum, high impedance by maximum.
// - Set A latencies run 4/20 up to 8/28; undefined at or below 800 MHz.
// - Set B latencies run 6/22 up to 24/44; undefined at or below 533 MHz.
// - Table turn-off latencies suit 16-beat bursts; 32-beat bursts add eight cycles.
// - Power-down keeps data-line termination off whatever the mode setting.
// - Self refresh: off while clock-enable low, on if high and enabled.
// - Write leveling with termination enabled terminates strobes continuously; disabled leaves them open.
// - Write leveling keeps all data and mask lines unterminated.
// - Termination field zero means disabled; any non-zero code enables it.
// - Codes 001b to 110b select reference resistor divided by one to six.
`ifndef DQTC_REGS_VH
`define DQTC_REGS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define DQTC_OFS_MODE 8'h00
`define DQTC_OFS_CFG 8'h04
`define DQTC_OFS_STAT 8'h08

// ************************************************************
// Fields
// ************************************************************
`define DQTC_MODE_CODE_MSB 2
`define DQTC_CFG_SETB_BIT 0
`define DQTC_CFG_BIN_LSB 1
`define DQTC_CFG_BIN_MSB 3
`define DQTC_CFG_BL32_BIT 4
`define DQTC_CFG_WLEV_BIT 5
`define DQTC_CFG_MSB 5

// ************************************************************
// Reset values
// ************************************************************
`define DQTC_MODE_RST 3'h0
`define DQTC_CFG_RST 6'h00

// ************************************************************
// Latency counts in cycles
// ************************************************************
`define DQTC_BL32_EXTRA 6'h08
`define DQTC_A_ON_3 6'h04
`define DQTC_A_ON_4 6'h04
`define DQTC_A_ON_5 6'h06
`define DQTC_A_ON_6 6'h06
`define DQTC_A_ON_7 6'h08
`define DQTC_A_OFF_3 6'h14
`define DQTC_A_OFF_4 6'h16
`define DQTC_A_OFF_5 6'h18
`define DQTC_A_OFF_6 6'h1a
`define DQTC_A_OFF_7 6'h1c
`define DQTC_B_ON_2 6'h06
`define DQTC_B_ON_3 6'h0c
`define DQTC_B_ON_4 6'h0e
`define DQTC_B_ON_5 6'h12
`define DQTC_B_ON_6 6'h14
`define DQTC_B_ON_7 6'h18
`define DQTC_B_OFF_2 6'h16
`define DQTC_B_OFF_3 6'h1c
`define DQTC_B_OFF_4 6'h20
`define DQTC_B_OFF_5 6'h24
`define DQTC_B_OFF_6 6'h28
`define DQTC_B_OFF_7 6'h2c

`endif

/* File: test/dqtc_properties.sv */
/* Checker of the termination outputs of dqtc_term_ctrl.
   Assumes it is bound to that module; mode and cfg writes are shadowed here. */
`timescale 1ns/1ps
`include "dqtc_regs.vh"
module dqtc_properties (
    input wire ref_clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire cmd_cas2,
    input wire power_down,
    input wire self_refresh,
    input wire cke_pin,
    input wire dq_term_en,
    input wire dqs_term_en,
    input wire [2:0] term_resistance_value
);
    // ********
    // Shadow state
    // ********
    reg [2:0] mode_ff;
    reg wlev_ff;
    reg [6:0] age_ff;
    reg [1:0] quiet_ff;
    wire norm = !power_down && !self_refresh && !wlev_ff && mode_ff != 3'h0;
    wire sr_ok = self_refresh && !power_down && !wlev_ff;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_ff <= 3'h0;
            wlev_ff <= 1'b0;
            age_ff <= 7'h7f;
            quiet_ff <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == `DQTC_OFS_MODE) begin
                mode_ff <= reg_wdata[2:0];
            end
            if (reg_wr && reg_addr == `DQTC_OFS_CFG) begin
                wlev_ff <= reg_wdata[`DQTC_CFG_WLEV_BIT];
            end
            // Saturates so a long idle spell still reads as old
            age_ff <= cmd_cas2 ? 7'h00 : (age_ff == 7'h7f ? age_ff : age_ff + 7'h01);
            quiet_ff <= !norm ? 2'h0 : (quiet_ff == 2'h3 ? quiet_ff : quiet_ff + 2'h1);
        end
    end
    // ********
    // Properties
    // ********
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    a_pd_both_off: assert property (
        power_down && $past(power_down) && !wlev_ff && !$past(wlev_ff) |-> !dq_term_en && !dqs_term_en)
        else $error("termination on in power-down");
    a_mode_zero_off: assert property (
        mode_ff == 3'h0 && $past(mode_ff) == 3'h0 |-> !dq_term_en && !dqs_term_en)
        else $error("termination on with code zero");
    a_wlev_dq_off: assert property (
        wlev_ff && $past(wlev_ff) |-> !dq_term_en)
        else $error("data lines terminated in leveling");
    a_wlev_dqs_on: assert property (
        wlev_ff && $past(wlev_ff) && mode_ff != 3'h0 && $past(mode_ff) != 3'h0 |-> dqs_term_en)
        else $error("strobes open in leveling");
    a_sr_cke_low: assert property (
        (sr_ok && !cke_pin) [*5] |-> !dq_term_en && !dqs_term_en)
        else $error("termination on with clock-enable low");
    a_sr_cke_high: assert property (
        (sr_ok && cke_pin && mode_ff != 3'h0) [*5] |-> dq_term_en && dqs_term_en)
        else $error("termination off with clock-enable high");
    a_code_copy: assert property (
        $stable(mode_ff) |-> term_resistance_value == mode_ff)
        else $error("strength code differs from mode");
    a_on_after_cas: assert property (
        norm && quiet_ff == 2'h3 && $rose(dq_term_en) |-> age_ff >= 7'h05 && age_ff <= 7'h19)
        else $error("termination on at wrong distance");
    a_off_after_cas: assert property (
        norm && quiet_ff == 2'h3 && $fell(dq_term_en) |-> age_ff >= 7'h15)
        else $error("termination off too early");
    a_idle_hiz: assert property (
        norm && quiet_ff == 2'h3 && age_ff >= 7'h3c |-> !dq_term_en)
        else $error("termination left on after burst");
endmodule
bind dqtc_term_ctrl dqtc_properties i_props (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .cmd_cas2,
    .power_down, .self_refresh, .cke_pin, .dq_term_en, .dqs_term_en, .term_resistance_value);

/* File: test/dqtc_ctrl_model.sv */
/* Memory-controller side: write commands, CAS-2 and power states.
   Assumes the caller starts each task after a rising clock edge. */
`timescale 1ns/1ps
module dqtc_ctrl_model (
    input wire ref_clk,
    output logic cmd_write1 = 1'b0,
    output logic cmd_mask_write1 = 1'b0,
    output logic cmd_mpc_wr_fifo = 1'b0,
    output logic cmd_cas2 = 1'b0,
    output logic power_down = 1'b0,
    output logic self_refresh = 1'b0,
    output logic cke_pin = 1'b1
);
    // Kind 3 sends CAS-2 alone, which the device must ignore
    task send_write(input int kind);
        @(posedge ref_clk);
        cmd_write1 <= (kind == 0);
        cmd_mask_write1 <= (kind == 1);
        cmd_mpc_wr_fifo <= (kind == 2);
        @(posedge ref_clk);
        cmd_write1 <= 1'b0;
        cmd_mask_write1 <= 1'b0;
        cmd_mpc_wr_fifo <= 1'b0;
        cmd_cas2 <= 1'b1;
        @(posedge ref_clk);
        cmd_cas2 <= 1'b0;
    endtask
    task set_state(input logic pd, input logic sr, input logic cke);
        @(posedge ref_clk);
        power_down <= pd;
        self_refresh <= sr;
        cke_pin <= cke;
    endtask
endmodule

/* File: test/dq_termination_timing_control_test.sv */
/* Self-checking bench of dqtc_term_ctrl.
   Assumes the partner model drives all command and state inputs. */
`timescale 1ns/1ps
`include "dqtc_regs.vh"
module dq_termination_timing_control_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] rd;
    logic [3:0] k;
    logic b32;
    wire [31:0] reg_rdata;
    wire cmd_w, cmd_mw, cmd_fifo, cmd_c2, pd, sr, cke, dq_en, dqs_en;
    wire [2:0] code_out;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int t_on, t_off;
    int lon [16] = '{0, 0, 0, 4, 4, 6, 6, 8, 0, 0, 6, 12, 14, 18, 20, 24};
    int loff [16] = '{0, 0, 0, 20, 22, 24, 26, 28, 0, 0, 22, 28, 32, 36, 40, 44};
    dqtc_term_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_write1(cmd_w), .cmd_mask_write1(cmd_mw),
        .cmd_mpc_wr_fifo(cmd_fifo), .cmd_cas2(cmd_c2), .power_down(pd), .self_refresh(sr), .cke_pin(cke),
        .dq_term_en(dq_en), .dqs_term_en(dqs_en), .term_resistance_value(code_out));
    dqtc_ctrl_model i_ctrl (.ref_clk(ref_clk), .cmd_write1(cmd_w), .cmd_mask_write1(cmd_mw),
        .cmd_mpc_wr_fifo(cmd_fifo), .cmd_cas2(cmd_c2), .power_down(pd), .self_refresh(sr), .cke_pin(cke));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Whole run needs about 1840 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // ********
    // Tasks
    // ********
    task stop_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task check_num(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("ERROR %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask
    task check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task check_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
        check_word(rd, exp);
    endtask
    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // First cycle with the line on and first cycle off again, counted from CAS-2
    task measure(input int kind, input int e_on, input int e_off);
        t_on = 0;
        t_off = 0;
        i_ctrl.send_write(kind);
        for (int n = 1; n < 80; n++) begin
            #1;
            t_on = (t_on == 0 && dq_en === 1'b1) ? n : t_on;
            t_off = (t_on != 0 && t_off == 0 && dq_en === 1'b0) ? n : t_off;
            @(posedge ref_clk);
        end
        check_num(t_on, e_on);
        check_num(t_off, e_off);
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        check_reg(`DQTC_OFS_MODE, 32'h0);
        check_reg(`DQTC_OFS_CFG, 32'h0);
        reg_write(8'h0c, 32'h7);
        check_reg(8'h0c, 32'h0);
        for (int c = 0; c < 8; c++) begin
            reg_write(`DQTC_OFS_MODE, 32'(c));
            check_reg(`DQTC_OFS_MODE, 32'(c));
            check_word({29'h0, code_out}, 32'(c));
        end
        reg_write(`DQTC_OFS_MODE, 32'h1);
        // Undefined bins must give no termination at all
        for (int i = 0; i < 17; i++) begin
            b32 = (i == 16);
            k = (i == 16) ? 4'hf : 4'(i);
            reg_write(`DQTC_OFS_CFG, {27'h0, b32, k[2:0], k[3]});
            measure(i % 3, lon[k] == 0 ? 0 : lon[k] + 2, lon[k] == 0 ? 0 : loff[k] + 8 * b32 + 2);
        end
        measure(3, 0, 0);
        reg_write(`DQTC_OFS_MODE, 32'h0);
        measure(0, 0, 0);
        reg_write(`DQTC_OFS_MODE, 32'h1);
        i_ctrl.set_state(1'b1, 1'b0, 1'b1);
        measure(1, 0, 0);
        i_ctrl.set_state(1'b0, 1'b1, 1'b0);
        settle(6);
        check_word({30'h0, dqs_en, dq_en}, 32'h0);
        i_ctrl.set_state(1'b0, 1'b1, 1'b1);
        settle(6);
        check_word({30'h0, dqs_en, dq_en}, 32'h3);
        reg_write(`DQTC_OFS_MODE, 32'h0);
        settle(3);
        check_word({30'h0, dqs_en, dq_en}, 32'h0);
        reg_write(`DQTC_OFS_MODE, 32'h1);
        i_ctrl.set_state(1'b0, 1'b0, 1'b1);
        reg_write(`DQTC_OFS_CFG, 32'h26);
        measure(0, 0, 0);
        settle(1);
        check_word({30'h0, dqs_en, dq_en}, 32'h2);
        check_reg(`DQTC_OFS_STAT, 32'h1c);
        reg_write(`DQTC_OFS_MODE, 32'h0);
        settle(3);
        check_word({30'h0, dqs_en, dq_en}, 32'h0);
        check_reg(`DQTC_OFS_STAT, 32'h18);
        stop_test();
    end
endmodule
